// ===== core/genset_alarm_monitor.sv
// Shutdown alarm monitor of a genset controller with an AXI4-Lite register slave.
// Assumes measured values arrive synchronous to aclk and are held stable between updates.
// Operation
// - Frequency outside low/high limits for its delay, after holdoff, sets an alarm.
// - Frequency above high limit plus 12 percent stops the engine at once, always.
// - Speed outside low/high limits for its delay, after holdoff, sets an alarm.
// - Speed above overshoot limit stops the engine at once, no holdoff.
// - Any phase voltage outside limits for voltage fail time, after holdoff, alarms.
// - Battery voltage outside limits for its delay alarms, engine state ignored.
// - Engine not running once all start attempts are used sets fail to start.
// - Engine still running when the stop timer expires sets fail to stop.
// - Charge voltage under its limit, after holdoff, sets an alarm.
// - No engine ECU message for 3 seconds while fuel is on alarms.
// - Phase voltage deviating from average beyond limit, after holdoff, alarms.
// - Phase current deviating beyond same limit, after holdoff, alarms at programmed level.
// - Current over limit for inverse time trips overcurrent at programmed level.
// - Currents back under limit abandon a pending overcurrent trip.
// - Pickup speed under crank cut speed for loss timer alarms, programmed level.
// - Any expired service counter raises the service request alarm.
// - Both keys held 5 seconds reset service counters and show completion.
// - Lost engine ECU communication raises an alarm.
// - Action levels of current unbalance, overcurrent, pickup and service alarms are configurable.
// - Shutdown lights alarm lamp, opens contactor, stops engine, drives alarm relay.
// - While a shutdown is active later alarms of any level are ignored.
// - Latching alarms stay active until an operating mode selection cancels them.
`timescale 1ns/1ps
`include "genset_alarm_map.svh"
module genset_alarm_monitor
  import genset_alarm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int unsigned ADDR_W      = 8
) (
  input  logic              aclk,
  input  logic              aresetn,
  input  logic [ADDR_W-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  input  logic [ADDR_W-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready,
  input  logic [15:0]       gen_freq,
  input  logic [15:0]       engine_rpm,
  input  logic [15:0]       volt_l1,
  input  logic [15:0]       volt_l2,
  input  logic [15:0]       volt_l3,
  input  logic [15:0]       curr_l1,
  input  logic [15:0]       curr_l2,
  input  logic [15:0]       curr_l3,
  input  logic [15:0]       battery_volt,
  input  logic [15:0]       charge_volt,
  input  logic              engine_running,
  input  logic              fuel_on,
  input  logic              stop_request,
  input  logic              crank_failed,
  input  logic              ecu_message,
  input  logic              ecu_link_lost,
  input  logic [2:0]        service_expired,
  input  logic              key_mute,
  input  logic              key_lamp_test,
  input  logic              mode_select,
  output logic              alarm_led,
  output logic              warning_led,
  output logic              gen_contactor_open,
  output logic              engine_stop,
  output logic              cooldown_stop,
  output logic              alarm_relay,
  output logic              service_reset,
  output logic              service_done
);
  state_s                 st;
  state_s                 n;
  logic [`NTMR-1:0]       cond;
  logic [`NTMR-1:0][15:0] lim;
  logic [`NTMR-1:0]       fire;
  logic [`NALM-1:0]       raw;
  logic [`NALM-1:0][1:0]  lv;
  logic [`NALM-1:0]       sdm;
  logic [`NALM-1:0]       ldm;
  logic [`NALM-1:0]       wnm;
  logic [`NALM-1:0]       base;
  logic [`NALM-1:0]       fresh;
  logic [17:0]            fthr;
  logic                   hok;
  logic                   oc_any;
  logic [15:0]            oc_max;
  logic                   keys;

  // A deviation test against the three-phase average; the average is truncated.
  function automatic logic unbal(input logic [15:0] a, input logic [15:0] b,
                                 input logic [15:0] c, input logic [15:0] l);
    logic [17:0] avg;
    logic [17:0] lim18;
    avg   = (18'(a) + 18'(b) + 18'(c)) / `NPH;
    lim18 = 18'(l);
    unbal = ((18'(a) > avg) ? 18'(a) - avg : avg - 18'(a)) > lim18 ||
            ((18'(b) > avg) ? 18'(b) - avg : avg - 18'(b)) > lim18 ||
            ((18'(c) > avg) ? 18'(c) - avg : avg - 18'(c)) > lim18;
  endfunction

  assign keys   = key_mute && key_lamp_test;
  assign hok    = engine_running && st.hold >= st.cfg[`R_DLY_A][`F_LO];
  assign fthr   = 18'(st.cfg[`R_FREQ][`F_HI]) +
                  18'(st.cfg[`R_FREQ][`F_HI]) * `OVF_NUM / `OVF_DEN;
  assign oc_max = (curr_l1 > curr_l2) ? ((curr_l1 > curr_l3) ? curr_l1 : curr_l3)
                                      : ((curr_l2 > curr_l3) ? curr_l2 : curr_l3);
  assign oc_any = oc_max > st.cfg[`R_LIM_C][`F_HI];

  always_comb begin
    cond[`T_FLO] = hok && gen_freq < st.cfg[`R_FREQ][`F_LO];
    cond[`T_FHI] = hok && gen_freq > st.cfg[`R_FREQ][`F_HI];
    cond[`T_RLO] = hok && engine_rpm < st.cfg[`R_RPM][`F_LO];
    cond[`T_RHI] = hok && engine_rpm > st.cfg[`R_RPM][`F_HI];
    cond[`T_VLO] = hok && (volt_l1 < st.cfg[`R_VOLT][`F_LO] ||
                   volt_l2 < st.cfg[`R_VOLT][`F_LO] || volt_l3 < st.cfg[`R_VOLT][`F_LO]);
    cond[`T_VHI] = hok && (volt_l1 > st.cfg[`R_VOLT][`F_HI] ||
                   volt_l2 > st.cfg[`R_VOLT][`F_HI] || volt_l3 > st.cfg[`R_VOLT][`F_HI]);
    cond[`T_BLO] = battery_volt < st.cfg[`R_BAT][`F_LO];
    cond[`T_BHI] = battery_volt > st.cfg[`R_BAT][`F_HI];
    cond[`T_VUB] = hok && unbal(volt_l1, volt_l2, volt_l3, st.cfg[`R_LIM_C][`F_LO]);
    cond[`T_IUB] = hok && unbal(curr_l1, curr_l2, curr_l3, st.cfg[`R_LIM_C][`F_LO]);
    cond[`T_PU]  = engine_running && engine_rpm < st.cfg[`R_DLY_D][`F_LO];
    cond[`T_STP] = stop_request && engine_running;
    lim[`T_FLO]  = st.cfg[`R_DLY_B][`F_LO];
    lim[`T_FHI]  = st.cfg[`R_DLY_B][`F_LO];
    lim[`T_RLO]  = st.cfg[`R_DLY_B][`F_HI];
    lim[`T_RHI]  = st.cfg[`R_DLY_B][`F_HI];
    lim[`T_VLO]  = st.cfg[`R_DLY_A][`F_HI];
    lim[`T_VHI]  = st.cfg[`R_DLY_A][`F_HI];
    lim[`T_BLO]  = st.cfg[`R_DLY_C][`F_LO];
    lim[`T_BHI]  = st.cfg[`R_DLY_C][`F_LO];
    lim[`T_VUB]  = st.cfg[`R_DLY_A][`F_HI];
    lim[`T_IUB]  = st.cfg[`R_DLY_A][`F_HI];
    lim[`T_PU]   = st.cfg[`R_DLY_C][`F_HI];
    lim[`T_STP]  = st.cfg[`R_CTRL][`F_LO];
  end

  always_comb begin
    n          = st;
    n.svc_rst  = 1'b0;
    n.tick     = 1'b0;
    // Delays count in millisecond ticks so that 16-bit timers reach about a minute.
    if (st.prs == 24'(TICK_CYCLES - 1)) begin
      n.prs  = '0;
      n.tick = 1'b1;
    end else begin
      n.prs = st.prs + 24'h1;
    end
    if (!engine_running) begin
      n.hold = '0;
    end else if (st.tick && !hok) begin
      n.hold = st.hold + 16'h1;
    end
    for (int k = 0; k < `NTMR; k++) begin
      if (!cond[k]) begin
        n.tmr[k] = '0;
      end else if (st.tick && st.tmr[k] < lim[k]) begin
        n.tmr[k] = st.tmr[k] + 16'h1;
      end
      fire[k] = cond[k] && st.tmr[k] >= lim[k];
    end
    // The curve integrates the excess per tick, so a larger overload reaches the
    // trip constant sooner; this is a linear stand-in for the full inverse curve.
    if (!oc_any) begin
      n.oc_acc = '0;
    end else if (st.tick && st.oc_acc < 32'(st.cfg[`R_DLY_D][`F_HI])) begin
      n.oc_acc = st.oc_acc + 32'(oc_max - st.cfg[`R_LIM_C][`F_HI]);
    end
    if (engine_running || mode_select) begin
      n.att = '0;
    end else if (crank_failed && st.att != 4'hf) begin
      n.att = st.att + 4'h1;
    end
    if (!fuel_on || ecu_message) begin
      n.ecu = '0;
    end else if (st.tick && st.ecu < 16'(`ECU_TIMEOUT_MS)) begin
      n.ecu = st.ecu + 16'h1;
    end
    raw          = '0;
    raw[`A_FLO]  = fire[`T_FLO];
    raw[`A_FHI]  = fire[`T_FHI];
    raw[`A_FOV]  = 18'(gen_freq) > fthr;
    raw[`A_RLO]  = fire[`T_RLO];
    raw[`A_RHI]  = fire[`T_RHI];
    raw[`A_ROV]  = engine_rpm > st.cfg[`R_LIM_B][`F_HI];
    raw[`A_VLO]  = fire[`T_VLO];
    raw[`A_VHI]  = fire[`T_VHI];
    raw[`A_BLO]  = fire[`T_BLO];
    raw[`A_BHI]  = fire[`T_BHI];
    raw[`A_FST]  = !engine_running && st.cfg[`R_CTRL][`F_ATT] != 4'h0 &&
                   st.att >= st.cfg[`R_CTRL][`F_ATT];
    raw[`A_FSP]  = fire[`T_STP];
    raw[`A_CHG]  = hok && charge_volt < st.cfg[`R_LIM_B][`F_LO];
    raw[`A_ECT]  = fuel_on && st.ecu >= 16'(`ECU_TIMEOUT_MS);
    raw[`A_ECL]  = ecu_link_lost;
    raw[`A_VUB]  = fire[`T_VUB];
    raw[`A_IUB]  = fire[`T_IUB];
    raw[`A_OC]   = oc_any && st.oc_acc >= 32'(st.cfg[`R_DLY_D][`F_HI]);
    raw[`A_PU]   = fire[`T_PU];
    raw[`A_SVC]  = |service_expired;
    for (int i = 0; i < `NALM; i++) begin
      lv[i] = `LV_SD;
    end
    lv[`A_IUB] = st.cfg[`R_CTRL][`F_ACT_IU];
    lv[`A_OC]  = st.cfg[`R_CTRL][`F_ACT_OC];
    lv[`A_PU]  = st.cfg[`R_CTRL][`F_ACT_PU];
    lv[`A_SVC] = st.cfg[`R_CTRL][`F_ACT_SV];
    for (int i = 0; i < `NALM; i++) begin
      sdm[i] = lv[i] == `LV_SD;
      ldm[i] = lv[i] == `LV_LD;
      wnm[i] = lv[i] == `LV_WARN;
    end
    // A mode selection cancels first, so a fault present in that cycle is kept.
    base  = mode_select ? '0 : st.alm & (st.cfg[`R_LATCH][`NALM-1:0] | raw);
    fresh = raw & ~base;
    if (|(base & sdm)) begin
      fresh = '0;
    end else if (|(base & ldm)) begin
      fresh = fresh & sdm;
    end else if (|(base & wnm)) begin
      fresh = fresh & (sdm | ldm);
    end else begin
      fresh = fresh & (sdm | ldm | wnm);
    end
    n.alm   = base | fresh;
    n.sd    = |(n.alm & sdm);
    n.ld    = |(n.alm & ldm);
    n.wn    = |(n.alm & wnm);
    n.led   = n.sd || n.ld;
    n.wled  = n.wn;
    n.relay = n.sd || n.ld || n.wn;
    unique case (st.kst)
      K_IDLE: begin
        n.key = '0;
        if (keys) begin
          n.kst      = K_HOLD;
          n.svc_done = 1'b0;
        end
      end
      K_HOLD: begin
        if (!keys) begin
          n.kst = K_IDLE;
        end else if (st.key >= 16'(`KEY_HOLD_MS)) begin
          n.kst      = K_DONE;
          n.svc_rst  = 1'b1;
          n.svc_done = 1'b1;
        end else if (st.tick) begin
          n.key = st.key + 16'h1;
        end
      end
      K_DONE: begin
        if (!keys) begin
          n.kst = K_IDLE;
        end
      end
      default: begin
        n.kst = K_IDLE;
      end
    endcase
    if (st.awr && awvalid) begin
      n.aw_ok = 1'b1;
      n.awi   = 6'(awaddr >> 2);
    end
    if (st.wr && wvalid) begin
      n.w_ok = 1'b1;
      n.wd   = wdata;
      n.ws   = wstrb;
    end
    if (st.aw_ok && st.w_ok) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (st.awi <= `R_STATUS) ? `RESP_OK : `RESP_ERR;
      if (st.awi < 6'(`NCFG)) begin
        for (int b = 0; b < 4; b++) begin
          if (st.ws[b]) begin
            n.cfg[st.awi[3:0]][8*b +: 8] = st.wd[8*b +: 8];
          end
        end
      end
    end
    if (st.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (st.arr && arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OK;
      n.rdata  = '0;
      if (6'(araddr >> 2) < 6'(`NCFG)) begin
        n.rdata = st.cfg[4'(araddr >> 2)];
      end else if (6'(araddr >> 2) == `R_ALARMS) begin
        n.rdata = 32'(st.alm);
      end else if (6'(araddr >> 2) == `R_STATUS) begin
        n.rdata = {26'h0, st.svc_done, st.wn, st.ld, st.sd, 2'(st.kst)};
      end else begin
        n.rresp = `RESP_ERR;
      end
    end
    n.awr = !n.aw_ok && !n.bvalid;
    n.wr  = !n.w_ok && !n.bvalid;
    n.arr = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st     <= '0;
      st.cfg <= {`NCFG{`CFG_RST}};
      st.kst <= K_IDLE;
    end else begin
      st <= n;
    end
  end

  assign awready            = st.awr;
  assign wready             = st.wr;
  assign bvalid             = st.bvalid;
  assign bresp              = st.bresp;
  assign arready            = st.arr;
  assign rvalid             = st.rvalid;
  assign rresp              = st.rresp;
  assign rdata              = st.rdata;
  assign alarm_led          = st.led;
  assign warning_led        = st.wled;
  assign gen_contactor_open = st.led;
  assign engine_stop        = st.sd;
  assign cooldown_stop      = st.ld;
  assign alarm_relay        = st.relay;
  assign service_reset      = st.svc_rst;
  assign service_done       = st.svc_done;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  over_freq_a: assert property (
    raw[`A_FOV] && !st.sd && !mode_select |=> st.alm[`A_FOV] && engine_stop)
    else $error("Frequency overshoot did not stop the engine.");
  over_rpm_a: assert property (
    raw[`A_ROV] && !st.sd && !mode_select |=> engine_stop && gen_contactor_open)
    else $error("Speed overshoot did not stop the engine.");
  holdoff_gate_a: assert property (
    !engine_running |-> (!cond[`T_FLO] && !cond[`T_RLO]) ##1 st.hold == 16'h0)
    else $error("Holdoff kept running while the engine was stopped.");
  first_only_a: assert property (
    st.sd && !mode_select |=> (st.alm & ~$past(st.alm)) == '0)
    else $error("A new alarm was accepted during a shutdown.");
  shutdown_out_a: assert property (
    st.sd |-> engine_stop && gen_contactor_open && alarm_led && alarm_relay)
    else $error("Shutdown outputs incomplete.");
  ecu_gate_a: assert property (
    !fuel_on |=> st.ecu == 16'h0)
    else $error("ECU timeout counted with fuel off.");
  timer_restart_a: assert property (
    !cond[`T_VLO] |=> st.tmr[`T_VLO] == 16'h0)
    else $error("Voltage delay not restarted.");
  oc_abandon_a: assert property (
    !oc_any && !st.alm[`A_OC] |=> st.oc_acc == 32'h0 && !st.alm[`A_OC])
    else $error("Overcurrent trip not abandoned.");
  key_hold_a: assert property (
    service_reset |-> $past(keys) && service_done && st.key >= 16'(`KEY_HOLD_MS))
    else $error("Service reset without a full key hold.");
  bresp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped before acceptance.");
endmodule

// ===== pkg/genset_alarm_map.svh
// Register offsets, field positions, alarm indices and timing figures of the alarm monitor.
// Included by the package and by the monitor; holds definitions only.
`ifndef GENSET_ALARM_MAP_SVH
`define GENSET_ALARM_MAP_SVH
`define CLK_PERIOD_NS  25
`define TICK_PERIOD_NS 1000000
`define ECU_TIMEOUT_MS 3000
`define KEY_HOLD_MS    5000
`define OVF_NUM        18'h3
`define OVF_DEN        18'h19
`define NPH            18'h3
`define NCFG           12
`define NTMR           12
`define NALM           20
`define R_FREQ         6'h0
`define R_RPM          6'h1
`define R_VOLT         6'h2
`define R_BAT          6'h3
`define R_LIM_B        6'h4
`define R_LIM_C        6'h5
`define R_DLY_A        6'h6
`define R_DLY_B        6'h7
`define R_DLY_C        6'h8
`define R_DLY_D        6'h9
`define R_CTRL         6'ha
`define R_LATCH        6'hb
`define R_ALARMS       6'hc
`define R_STATUS       6'hd
`define CFG_RST        32'h0000_0000
`define F_LO           15:0
`define F_HI           31:16
`define F_ATT          19:16
`define F_ACT_IU       25:24
`define F_ACT_OC       27:26
`define F_ACT_PU       29:28
`define F_ACT_SV       31:30
`define A_FLO  0
`define A_FHI  1
`define A_FOV  2
`define A_RLO  3
`define A_RHI  4
`define A_ROV  5
`define A_VLO  6
`define A_VHI  7
`define A_BLO  8
`define A_BHI  9
`define A_FST  10
`define A_FSP  11
`define A_CHG  12
`define A_ECT  13
`define A_ECL  14
`define A_VUB  15
`define A_IUB  16
`define A_OC   17
`define A_PU   18
`define A_SVC  19
`define T_FLO  0
`define T_FHI  1
`define T_RLO  2
`define T_RHI  3
`define T_VLO  4
`define T_VHI  5
`define T_BLO  6
`define T_BHI  7
`define T_VUB  8
`define T_IUB  9
`define T_PU   10
`define T_STP  11
`define LV_NONE 2'h0
`define LV_WARN 2'h1
`define LV_LD   2'h2
`define LV_SD   2'h3
`define RESP_OK  2'h0
`define RESP_ERR 2'h2
`endif

// ===== pkg/genset_alarm_pkg.sv
// Types of the alarm monitor: key hold states and the monitor's whole state.
// Relies on the constants of genset_alarm_map.svh.
`include "genset_alarm_map.svh"
package genset_alarm_pkg;
  typedef enum logic [1:0] {
    K_IDLE = 2'b00,
    K_HOLD = 2'b01,
    K_DONE = 2'b11
  } key_e;

  typedef struct packed {
    logic [`NCFG-1:0][31:0] cfg;
    logic                   awr;
    logic                   wr;
    logic                   aw_ok;
    logic                   w_ok;
    logic [5:0]             awi;
    logic [31:0]            wd;
    logic [3:0]             ws;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arr;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic [23:0]            prs;
    logic                   tick;
    logic [15:0]            hold;
    logic [`NTMR-1:0][15:0] tmr;
    logic [31:0]            oc_acc;
    logic [3:0]             att;
    logic [15:0]            ecu;
    logic [15:0]            key;
    key_e                   kst;
    logic [`NALM-1:0]       alm;
    logic                   sd;
    logic                   ld;
    logic                   wn;
    logic                   led;
    logic                   wled;
    logic                   relay;
    logic                   svc_rst;
    logic                   svc_done;
  } state_s;
endpackage

// ===== verification/ecu_link_model.sv
// Engine ECU link model: one message pulse every 64 clocks while talk is high.
// Assumes the bench owns aclk and aresetn and changes talk just after a rising edge.
`timescale 1ns/1ps
module ecu_link_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic talk,
  input  wire logic drop,
  output logic      ecu_message,
  output logic      ecu_link_lost
);
  logic [5:0] cnt;
  // The lost flag follows drop one clock late, as a bus front end would report it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt           <= 6'h0;
      ecu_message   <= 1'b0;
      ecu_link_lost <= 1'b0;
    end else begin
      ecu_link_lost <= drop;
      cnt         <= cnt + 6'h1;
      ecu_message <= talk && (cnt == 6'h3f);
    end
  end
endmodule

// ===== verification/genset_shutdown_alarm_monitor_test.sv
// Bench of the alarm monitor: register bus tasks and one task per scenario.
// Assumes TICK_CYCLES of 4, so one tick lasts four clocks.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module genset_shutdown_alarm_monitor_test;
  import genset_alarm_pkg::*;
  localparam int TK = 4;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, talk = 1'b0, drop = 1'b0;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  rs, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [15:0] gen_freq = 16'h0, engine_rpm = 16'h0, battery_volt = 16'h0;
  logic [15:0] volt_l1 = 16'h0, volt_l2 = 16'h0, volt_l3 = 16'h0, charge_volt = 16'h0;
  logic [15:0] curr_l1 = 16'h0, curr_l2 = 16'h0, curr_l3 = 16'h0;
  logic        engine_running = 1'b0, fuel_on = 1'b0, stop_request = 1'b0;
  logic        crank_failed = 1'b0, key_mute = 1'b0, key_lamp_test = 1'b0;
  logic        mode_select = 1'b0, ecu_message, ecu_link_lost;
  logic [2:0]  service_expired = 3'h0;
  logic        alarm_led, warning_led, gen_contactor_open, engine_stop;
  logic        cooldown_stop, alarm_relay, service_reset, service_done;

  genset_alarm_monitor #(.TICK_CYCLES(TK)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .gen_freq, .engine_rpm, .volt_l1, .volt_l2, .volt_l3, .curr_l1,
    .curr_l2, .curr_l3, .battery_volt, .charge_volt, .engine_running, .fuel_on,
    .stop_request, .crank_failed, .ecu_message, .ecu_link_lost, .service_expired,
    .key_mute, .key_lamp_test, .mode_select, .alarm_led, .warning_led,
    .gen_contactor_open, .engine_stop, .cooldown_stop, .alarm_relay,
    .service_reset, .service_done);
  ecu_link_model ecu_u (.aclk, .aresetn, .talk, .drop, .ecu_message, .ecu_link_lost);

  always #12.5 aclk = ~aclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The ceiling allows about one and a half times the whole run, mostly the key hold.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 50000) begin
      err_total++;
      test_done();
    end
  end

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr  <= {i, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", 2'h0, bresp)
  endtask

  task automatic rdr(input logic [5:0] i);
    @(posedge aclk);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Waits for engine_stop to reach v, giving up after lim clocks.
  task automatic wait_sd(input logic v, input int lim);
    n = 0;
    while (engine_stop !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic t_bus();
    rdr(6'h0);
    `CHK("freq reset", 32'h0, rd)
    rdr(6'he);
    `CHK("unmapped resp", 2'h2, rs)
    `CHK("unmapped data", 32'h0, rd)
    wr(6'h0, 32'h0064_0028);
    rdr(6'h0);
    `CHK("freq limits", 32'h0064_0028, rd)
    $display("t_bus end");
  endtask

  task automatic t_bat();
    wr(6'h8, 32'h0000_0005);
    battery_volt <= 16'd200;
    wr(6'h3, 32'h012c_0064);
    battery_volt <= 16'd301;
    repeat (3 * TK) @(posedge aclk);
    battery_volt <= 16'd200;
    repeat (8) @(posedge aclk);
    `CHK("short high", 1'b0, engine_stop)
    battery_volt <= 16'd301;
    wait_sd(1'b1, 80);
    `CHK("bat stop", 1'b1, engine_stop)
    `CHK("bat delay", 1'b1, n >= 4 * TK)
    rdr(6'hc);
    `CHK("bat hi bit", 1'b1, rd[9])
    battery_volt <= 16'd200;
    wait_sd(1'b0, 8);
    `CHK("bat clear", 1'b0, engine_stop)
    $display("t_bat end");
  endtask

  task automatic t_fov();
    wr(6'hb, 32'h0000_0004);
    gen_freq <= 16'd113;
    wait_sd(1'b1, 4);
    `CHK("fov stop", 1'b1, engine_stop)
    `CHK("alarm led", 1'b1, alarm_led)
    `CHK("contactor", 1'b1, gen_contactor_open)
    `CHK("relay", 1'b1, alarm_relay)
    rdr(6'hc);
    `CHK("fov bit", 1'b1, rd[2])
    gen_freq <= 16'd112;
    repeat (8) @(posedge aclk);
    `CHK("latched", 1'b1, engine_stop)
    mode_select <= 1'b1;
    @(posedge aclk);
    mode_select <= 1'b0;
    wait_sd(1'b0, 8);
    `CHK("cancelled", 1'b0, engine_stop)
    repeat (20) @(posedge aclk);
    `CHK("at limit", 1'b0, engine_stop)
    wr(6'hb, 32'h0);
    $display("t_fov end");
  endtask

  task automatic t_hold();
    wr(6'h6, 32'h0000_0003);
    wr(6'h7, 32'h0000_0002);
    gen_freq       <= 16'd30;
    engine_running <= 1'b1;
    repeat (3 * TK) @(posedge aclk);
    `CHK("holdoff", 1'b0, engine_stop)
    wait_sd(1'b1, 40);
    `CHK("freq low", 1'b1, engine_stop)
    engine_running <= 1'b0;
    wait_sd(1'b0, 8);
    `CHK("engine off", 1'b0, engine_stop)
    engine_rpm <= 16'd1;
    wait_sd(1'b1, 4);
    `CHK("rpm overshoot", 1'b1, engine_stop)
    engine_rpm <= 16'd0;
    gen_freq   <= 16'd0;
    wait_sd(1'b0, 8);
    `CHK("rpm clear", 1'b0, engine_stop)
    $display("t_hold end");
  endtask

  task automatic t_lvl();
    wr(6'ha, 32'h4800_0000);
    wr(6'h9, 32'h0028_0000);
    service_expired <= 3'h2;
    repeat (3) @(posedge aclk);
    `CHK("warn led", 1'b1, warning_led)
    `CHK("warn relay", 1'b1, alarm_relay)
    `CHK("warn lamp", 1'b0, alarm_led)
    curr_l1 <= 16'd10;
    repeat (3 * TK) @(posedge aclk);
    curr_l1 <= 16'd0;
    @(posedge aclk);
    curr_l1 <= 16'd10;
    repeat (3 * TK) @(posedge aclk);
    `CHK("oc abandoned", 1'b0, cooldown_stop)
    curr_l1 <= 16'd40;
    repeat (3 * TK) @(posedge aclk);
    `CHK("oc trip", 1'b1, cooldown_stop)
    `CHK("oc level", 1'b0, engine_stop)
    `CHK("ld lamp", 1'b1, alarm_led)
    curr_l1         <= 16'd0;
    service_expired <= 3'h0;
    repeat (3) @(posedge aclk);
    `CHK("lvl clear", 1'b0, alarm_relay)
    wr(6'ha, 32'h0);
    $display("t_lvl end");
  endtask

  task automatic t_key();
    key_mute      <= 1'b1;
    key_lamp_test <= 1'b1;
    repeat (4900 * TK) @(posedge aclk);
    `CHK("key early", 1'b0, service_done)
    n = 0;
    while (!service_reset && n < 600) begin
      @(posedge aclk);
      n++;
    end
    `CHK("svc reset", 1'b1, service_reset)
    `CHK("svc done", 1'b1, service_done)
    key_mute      <= 1'b0;
    key_lamp_test <= 1'b0;
    $display("t_key end");
  endtask

  task automatic t_ecu();
    fuel_on <= 1'b1;
    talk    <= 1'b1;
    repeat (400) @(posedge aclk);
    `CHK("ecu talking", 1'b0, engine_stop)
    talk <= 1'b0;
    repeat (2900 * TK) @(posedge aclk);
    `CHK("ecu early", 1'b0, engine_stop)
    wait_sd(1'b1, 500);
    `CHK("ecu stop", 1'b1, engine_stop)
    rdr(6'hc);
    `CHK("ecu bit", 1'b1, rd[13])
    fuel_on <= 1'b0;
    wait_sd(1'b0, 8);
    `CHK("fuel off", 1'b0, engine_stop)
    drop <= 1'b1;
    wait_sd(1'b1, 8);
    `CHK("link lost", 1'b1, engine_stop)
    drop <= 1'b0;
    wait_sd(1'b0, 8);
    `CHK("link back", 1'b0, engine_stop)
    $display("t_ecu end");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_bat();
    t_fov();
    t_hold();
    t_lvl();
    t_ecu();
    t_key();
    test_done();
  end
endmodule
